// ===== verilog/dt_pkg.sv
package dt_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned BASE_TICK_MS = 10;
    localparam int unsigned CYC_PER_BASE = CLK_HZ / 1000 * BASE_TICK_MS;
    localparam int unsigned BASE_PER_SEC = 100;
    localparam int unsigned SEC_PER_MIN = 60;

    localparam logic [31:0] REF_MAX_MS = 32'h0001_8696;
    localparam logic [31:0] REF_MAX_S = 32'h0000_176F;
    localparam logic [31:0] MS_PER_TICK = 32'h0000_000A;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RISE_PAR = 8'h04;
    localparam logic [7:0] OFF_FALL_PAR = 8'h08;
    localparam logic [7:0] OFF_REF_SEL = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_ELAPSED = 8'h14;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_USE_REF_BIT = 2;
    localparam int CTRL_FIX_TB_LSB = 4;
    localparam int CTRL_REF_TB_LSB = 6;
    localparam int SEL_RISE_LSB = 0;
    localparam int SEL_FALL_LSB = 8;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] RISE_PAR_RESET = 16'h0064;
    localparam logic [15:0] FALL_PAR_RESET = 16'h0064;
    localparam logic [15:0] REF_SEL_RESET = 16'h0000;

    typedef enum logic [1:0] {
        DT_MODE_ON = 2'b00,
        DT_MODE_OFF = 2'b01,
        DT_MODE_ONOFF = 2'b10
    } dt_mode_e;

    typedef enum logic [1:0] {
        DT_TB_FINE = 2'b00,
        DT_TB_SEC = 2'b01,
        DT_TB_MIN = 2'b10
    } dt_tb_e;

endpackage

// ===== verilog/dt_prescaler.sv
`timescale 1ns/1ps
module dt_prescaler
    import dt_pkg::*;
#(
    parameter int unsigned CYC_PER_TICK = CYC_PER_BASE
) (
    input wire logic clk_sys,
    input wire logic reset,
    output logic [2:0] tick_vec
);
    logic [31:0] cyc_q;
    logic [6:0] base_q;
    logic [5:0] sec_q;
    logic base_tick;
    logic sec_tick;
    logic min_tick;

    // Cascaded counters keep all three ticks aligned to the same edge
    assign base_tick = (cyc_q == 32'(CYC_PER_TICK - 1));
    assign sec_tick = base_tick && (base_q == 7'(BASE_PER_SEC - 1));
    assign min_tick = sec_tick && (sec_q == 6'(SEC_PER_MIN - 1));
    assign tick_vec = {min_tick, sec_tick, base_tick};

    always_ff @(posedge clk_sys) begin
        if (reset || base_tick) begin
            cyc_q <= 32'h0000_0000;
        end else begin
            cyc_q <= cyc_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || sec_tick) begin
            base_q <= 7'h00;
        end else if (base_tick) begin
            base_q <= base_q + 7'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || min_tick) begin
            sec_q <= 6'h00;
        end else if (sec_tick) begin
            sec_q <= sec_q + 6'h01;
        end
    end
endmodule

// ===== verilog/dt_timer.sv
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module dt_timer
    import dt_pkg::*;
#(
    parameter int unsigned CYC_PER_TICK = CYC_PER_BASE,
    parameter int unsigned NUM_REFS = 8
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic trigger_in,
    input wire logic clear_in,
    input wire logic [NUM_REFS*32-1:0] ref_values,
    input wire logic retain_en,
    input wire logic ret_timed_out,
    input wire logic [15:0] ret_elapsed,
    input wire logic ret_running,
    input wire logic ret_phase_fall,
    output logic timed_out,
    output logic [15:0] elapsed_time,
    output logic running,
    output logic phase_fall
);
    logic [7:0] ctrl_q;
    logic [15:0] rise_par_q;
    logic [15:0] fall_par_q;
    logic [15:0] ref_sel_q;
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic restore_q;
    logic trig_prev_q;
    logic timed_out_q;
    logic [15:0] elapsed_q;
    logic run_q;
    logic phase_fall_q;
    logic [2:0] tick_vec;
    logic tick;
    logic use_ref;
    logic [1:0] tb_sel;
    logic [1:0] mode;
    logic [15:0] rise_ticks;
    logic [15:0] fall_ticks;
    logic [15:0] target;
    logic expire;
    logic trig_rise;
    logic trig_fall;
    logic start;
    logic start_fall;
    logic stop;
    logic addr_phase;

    // Clamps a signed referenced value and converts it to timebase ticks
    function automatic logic [15:0] ref_to_ticks(input logic [31:0] val, input logic [1:0] tb);
        logic [31:0] lim;
        logic [31:0] v;
        lim = (tb == DT_TB_FINE) ? REF_MAX_MS : REF_MAX_S;
        v = val[31] ? 32'h0000_0000 : val;
        if (v > lim) begin
            v = lim;
        end
        if (tb == DT_TB_FINE) begin
            v = v / MS_PER_TICK;
        end
        return v[15:0];
    endfunction

    // Picks a referenced block's value by its block number
    function automatic logic [31:0] ref_pick(input logic [7:0] blk);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int i = 0; i < NUM_REFS; i++) begin
            if (blk == 8'(i)) begin
                r = ref_values[i*32 +: 32];
            end
        end
        return r;
    endfunction

    dt_prescaler #(
        .CYC_PER_TICK(CYC_PER_TICK)
    ) u_prescaler (
        .clk_sys(clk_sys),
        .reset(reset),
        .tick_vec(tick_vec)
    );

    assign mode = ctrl_q[CTRL_MODE_LSB +: 2];
    assign use_ref = ctrl_q[CTRL_USE_REF_BIT];
    assign tb_sel = use_ref ? ctrl_q[CTRL_REF_TB_LSB +: 2] : ctrl_q[CTRL_FIX_TB_LSB +: 2];
    // Code 3 falls back to the coarsest base rather than stalling the timer
    assign tick = (tb_sel == DT_TB_FINE) ? tick_vec[0] :
                  (tb_sel == DT_TB_SEC) ? tick_vec[1] : tick_vec[2];

    assign rise_ticks = use_ref ? ref_to_ticks(ref_pick(ref_sel_q[SEL_RISE_LSB +: 8]), tb_sel)
                                : rise_par_q;
    assign fall_ticks = use_ref ? ref_to_ticks(ref_pick(ref_sel_q[SEL_FALL_LSB +: 8]), tb_sel)
                                : fall_par_q;
    assign target = phase_fall_q ? fall_ticks : rise_ticks;
    assign expire = run_q && (elapsed_q >= target);

    assign trig_rise = trigger_in && !trig_prev_q;
    assign trig_fall = !trigger_in && trig_prev_q;

    always_comb begin
        start = 1'b0;
        start_fall = 1'b0;
        stop = 1'b0;
        unique case (mode)
            DT_MODE_ON: begin
                start = trig_rise;
                stop = !trigger_in || expire;
            end
            DT_MODE_OFF: begin
                start = trig_fall && !clear_in;
                stop = trigger_in || clear_in || expire;
            end
            DT_MODE_ONOFF: begin
                start = (trig_rise && !timed_out_q) || (trig_fall && timed_out_q);
                start_fall = trig_fall;
                stop = (trig_fall && !timed_out_q) || (trig_rise && timed_out_q) || expire;
            end
            default: begin
                stop = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            restore_q <= 1'b1;
        end else begin
            restore_q <= 1'b0;
        end
    end

    // Restore runs one edge after reset release, so reset itself loads only constants
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            trig_prev_q <= 1'b0;
        end else if (restore_q) begin
            trig_prev_q <= trigger_in;
        end else begin
            trig_prev_q <= trigger_in;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            elapsed_q <= 16'h0000;
            run_q <= 1'b0;
            phase_fall_q <= 1'b0;
        end else if (restore_q) begin
            elapsed_q <= retain_en ? ret_elapsed : 16'h0000;
            run_q <= retain_en && ret_running;
            phase_fall_q <= retain_en && ret_phase_fall;
        end else if (start) begin
            elapsed_q <= 16'h0000;
            run_q <= 1'b1;
            phase_fall_q <= start_fall;
        end else if (stop) begin
            run_q <= 1'b0;
            if (!expire || (mode == DT_MODE_OFF && clear_in)) begin
                elapsed_q <= 16'h0000;
            end
        end else if (run_q && tick) begin
            elapsed_q <= elapsed_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            timed_out_q <= 1'b0;
        end else if (restore_q) begin
            timed_out_q <= retain_en && ret_timed_out;
        end else begin
            unique case (mode)
                DT_MODE_ON: begin
                    if (!trigger_in) begin
                        timed_out_q <= 1'b0;
                    end else if (expire) begin
                        timed_out_q <= 1'b1;
                    end
                end
                DT_MODE_OFF: begin
                    if (clear_in) begin
                        timed_out_q <= 1'b0;
                    end else if (trigger_in) begin
                        timed_out_q <= 1'b1;
                    end else if (expire) begin
                        timed_out_q <= 1'b0;
                    end
                end
                DT_MODE_ONOFF: begin
                    if (expire && !start && !stop_edge(trig_rise, trig_fall)) begin
                        if (!phase_fall_q && trigger_in) begin
                            timed_out_q <= 1'b1;
                        end else if (phase_fall_q && !trigger_in) begin
                            timed_out_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    timed_out_q <= 1'b0;
                end
            endcase
        end
    end

    // An edge in the expiry cycle cancels that expiry
    function automatic logic stop_edge(input logic r, input logic f);
        return r || f;
    endfunction

    assign timed_out = timed_out_q;
    assign elapsed_time = elapsed_q;
    assign running = run_q;
    assign phase_fall = phase_fall_q;

    // Zero-wait slave; reads come from the live registers in the data phase
    assign addr_phase = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= addr_phase && hwrite && (hsize == 3'b010);
            rd_pend_q <= addr_phase && !hwrite;
            addr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET;
            rise_par_q <= RISE_PAR_RESET;
            fall_par_q <= FALL_PAR_RESET;
            ref_sel_q <= REF_SEL_RESET;
        end else if (wr_pend_q) begin
            unique case (addr_q)
                OFF_CTRL: ctrl_q <= hwdata[7:0];
                OFF_RISE_PAR: rise_par_q <= hwdata[15:0];
                OFF_FALL_PAR: fall_par_q <= hwdata[15:0];
                OFF_REF_SEL: ref_sel_q <= hwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        hrdata = 32'h0000_0000;
        if (rd_pend_q) begin
            unique case (addr_q)
                OFF_CTRL: hrdata = {24'h00_0000, ctrl_q};
                OFF_RISE_PAR: hrdata = {16'h0000, rise_par_q};
                OFF_FALL_PAR: hrdata = {16'h0000, fall_par_q};
                OFF_REF_SEL: hrdata = {16'h0000, ref_sel_q};
                OFF_STATUS: hrdata = {28'h000_0000, phase_fall_q, run_q, trigger_in, timed_out_q};
                OFF_ELAPSED: hrdata = {16'h0000, elapsed_q};
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end
endmodule

// ===== testbench/dt_src_model.sv
`timescale 1ns/1ps
module dt_src_model (
    input wire logic clk_sys,
    input wire logic trg_req,
    input wire logic clr_req,
    input wire logic [63:0] vals,
    output logic trigger_in,
    output logic clear_in,
    output logic [63:0] ref_values
);
    // Same-clock neighbour blocks: their levels move only at the edge
    always_ff @(posedge clk_sys) begin
        trigger_in <= trg_req;
        clear_in <= clr_req;
        ref_values <= vals;
    end
endmodule

// ===== testbench/dt_timer_monitor.sv
`timescale 1ns/1ps
module dt_timer_monitor
    import dt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic trigger_in,
    input wire logic clear_in,
    input wire logic timed_out,
    input wire logic [15:0] elapsed_time,
    input wire logic running
);
    // Mode and delay shadowed from bus writes, as only ports are seen
    logic wr_q;
    logic [7:0] adr_q;
    logic [7:0] ctl_q;
    logic [15:0] dly_q;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_q <= 1'b0;
            ctl_q <= CTRL_RESET;
            dly_q <= RISE_PAR_RESET;
        end else begin
            wr_q <= hsel && htrans[1] && hready && hwrite;
            adr_q <= haddr[7:0];
            if (wr_q && adr_q == OFF_CTRL) begin
                ctl_q <= hwdata[7:0];
            end
            if (wr_q && adr_q == OFF_RISE_PAR) begin
                dly_q <= hwdata[15:0];
            end
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    rst_zero_a: assert property (disable iff (1'b0) reset
        |=> !timed_out && elapsed_time == 16'h0 && !running)
        else $error("reset left outputs set");
    on_start_a: assert property (ctl_q[1:0] == DT_MODE_ON && !$past(reset) && $rose(trigger_in)
        |=> running && elapsed_time == 16'h0)
        else $error("on-delay did not start");
    on_expire_a: assert property (ctl_q[2:0] == 3'h0 && running && trigger_in
        && elapsed_time >= dly_q |=> timed_out)
        else $error("on-delay did not expire");
    on_low_a: assert property (ctl_q[1:0] == DT_MODE_ON && !$past(reset) && !trigger_in
        |=> !timed_out)
        else $error("on-delay output high with trigger low");
    off_set_a: assert property (ctl_q[1:0] == DT_MODE_OFF && trigger_in && !clear_in
        |=> timed_out)
        else $error("off-delay output not set at once");
    off_fall_a: assert property (ctl_q[1:0] == DT_MODE_OFF && timed_out && $fell(trigger_in)
        && !clear_in |=> timed_out && elapsed_time == 16'h0)
        else $error("off-delay fall did not restart");
    off_clear_a: assert property (ctl_q[1:0] == DT_MODE_OFF && clear_in |=> !timed_out)
        else $error("clear did not drop output");
    onoff_early_a: assert property (ctl_q[1:0] == DT_MODE_ONOFF && !timed_out && $fell(trigger_in)
        |=> !timed_out)
        else $error("early fall set output");
    onoff_keep_a: assert property (ctl_q[1:0] == DT_MODE_ONOFF && timed_out && $rose(trigger_in)
        |=> timed_out)
        else $error("early rise dropped output");
endmodule
bind dt_timer dt_timer_monitor dt_timer_monitor_inst (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .trigger_in(trigger_in),
    .clear_in(clear_in), .timed_out(timed_out), .elapsed_time(elapsed_time), .running(running));

// ===== testbench/tb_dt_timer.sv
`timescale 1ns/1ps
module tb_dt_timer
    import dt_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic trg = 1'b0;
    logic clr = 1'b0;
    logic [63:0] vals = 64'h0;
    logic trigger_in;
    logic clear_in;
    logic [63:0] ref_values;
    logic retain_en = 1'b0;
    logic timed_out;
    logic [15:0] elapsed_time;
    logic running;
    logic phase_fall;
    logic ret_timed_out = 1'b1;
    logic [15:0] ret_elapsed = 16'h0005;
    logic ret_running = 1'b0;
    logic ret_phase_fall = 1'b1;
    logic [31:0] rd;
    int err_total = 0;
    int checks_done = 0;
    // Mode, cycles high, output then, cycles low, output then
    int rows [7][5] = '{'{0, 30, 1, 30, 0}, '{0, 8, 0, 30, 0}, '{1, 30, 1, 8, 1}, '{1, 30, 1, 30, 0},
        '{2, 30, 1, 8, 1}, '{2, 30, 1, 30, 0}, '{2, 8, 0, 30, 0}};
    logic [7:0] offs [5] = '{OFF_CTRL, OFF_RISE_PAR, OFF_FALL_PAR, OFF_REF_SEL, 8'h20};
    logic [31:0] rstv [5] = '{32'h0, 32'h64, 32'h64, 32'h0, 32'h0};
    always #50 clk_sys = ~clk_sys;
    dt_src_model dt_src_model_inst (.clk_sys(clk_sys), .trg_req(trg), .clr_req(clr), .vals(vals),
        .trigger_in(trigger_in), .clear_in(clear_in), .ref_values(ref_values));
    dt_timer #(.CYC_PER_TICK(4), .NUM_REFS(2)) dt_timer_inst (.clk_sys(clk_sys), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trigger_in(trigger_in), .clear_in(clear_in),
        .ref_values(ref_values), .retain_en(retain_en), .ret_timed_out(ret_timed_out), .ret_elapsed(ret_elapsed),
        .ret_running(ret_running), .ret_phase_fall(ret_phase_fall), .timed_out(timed_out),
        .elapsed_time(elapsed_time), .running(running), .phase_fall(phase_fall));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic hold(input logic lvl, input int n, input logic e);
        trg <= lvl;
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("timed_out", timed_out, e);
        @(posedge clk_sys);
    endtask
    task automatic do_reset(input logic keep);
        retain_en <= keep;
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic give_verdict();
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        do_reset(1'b0);
        @(posedge clk_sys);
        bus(1'b1, OFF_RISE_PAR, 32'h3, rd);
        bus(1'b1, OFF_FALL_PAR, 32'h3, rd);
        foreach (rows[i]) begin
            hold(1'b0, 40, 1'b0);
            bus(1'b1, OFF_CTRL, 32'(rows[i][0]), rd);
            hold(1'b1, rows[i][1], rows[i][2][0]);
            hold(1'b0, rows[i][3], rows[i][4][0]);
        end
        bus(1'b1, OFF_CTRL, 32'h1, rd);
        hold(1'b1, 20, 1'b1);
        hold(1'b0, 3, 1'b1);
        clr <= 1'b1;
        hold(1'b0, 2, 1'b0);
        chk("elapsed", elapsed_time, 32'h0);
        clr <= 1'b0;
        bus(1'b1, OFF_CTRL, 32'h2, rd);
        hold(1'b1, 30, 1'b1);
        hold(1'b0, 4, 1'b1);
        hold(1'b1, 30, 1'b1);
        // Fixed delay made long so only the referenced value can expire
        vals <= 64'h1E;
        bus(1'b1, OFF_RISE_PAR, 32'h64, rd);
        bus(1'b1, OFF_CTRL, 32'h4, rd);
        hold(1'b0, 40, 1'b0);
        hold(1'b1, 30, 1'b1);
        vals <= 64'hFFFF_FFFB;
        hold(1'b0, 40, 1'b0);
        hold(1'b1, 12, 1'b1);
        // Two seconds, since the free-running tick phase puts expiry 400 to 800 cycles after start
        vals <= 64'h2;
        bus(1'b1, OFF_CTRL, 32'h44, rd);
        hold(1'b0, 40, 1'b0);
        hold(1'b1, 390, 1'b0);
        hold(1'b1, 420, 1'b1);
        do_reset(1'b1);
        chk("kept out", timed_out, 32'h1);
        chk("kept time", elapsed_time, 32'h5);
        chk("kept run", running, 32'h0);
        chk("kept phase", phase_fall, 32'h1);
        @(posedge clk_sys);
        do_reset(1'b0);
        chk("def out", timed_out, 32'h0);
        chk("def time", elapsed_time, 32'h0);
        chk("def phase", phase_fall, 32'h0);
        @(posedge clk_sys);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF, rd);
        foreach (offs[i]) begin
            bus(1'b0, offs[i], 32'h0, rd);
            chk("reg", rd, rstv[i]);
        end
        bus(1'b1, OFF_FALL_PAR, 32'h1234, rd);
        bus(1'b0, OFF_FALL_PAR, 32'h0, rd);
        chk("fall par", rd, 32'h1234);
        bus(1'b0, OFF_STATUS, 32'h0, rd);
        chk("status", rd, 32'h2);
        chk("resp", hresp, 32'h0);
        give_verdict();
    end
    // About seventeen times the expected run length
    initial begin
        #3_000_000;
        err_total++;
        give_verdict();
    end
endmodule
